// ==== hw/ctmc_params.svh ====
// Constants of the CAN transceiver mode controller.
`ifndef CTMC_PARAMS_SVH
`define CTMC_PARAMS_SVH

// Depth of the receive-bit buffer and the width of its pointers.
`define CTMC_BUF_DEPTH     2
`define CTMC_BUF_PTR_W     1
`define CTMC_BUF_CNT_W     2
`define CTMC_BUF_FULL_CNT  2'h2

// Mode register encodings, Gray coded along power-down, normal, receive-only, standby.
`define CTMC_MODE_PWRDN    2'h0
`define CTMC_MODE_NORMAL   2'h1
`define CTMC_MODE_RXONLY   2'h3
`define CTMC_MODE_STANDBY  2'h2

// Receive data level for a recessive bus.
`define CTMC_RX_RECESSIVE  1'h1

`endif

// ==== hw/ctmc_pkg.sv ====
// Types of the CAN transceiver mode controller.
`include "ctmc_params.svh"

package ctmc_pkg;

	// Operating mode; power-down is the reset state.
	typedef enum logic [1:0] {
		CTMC_PWRDN   = `CTMC_MODE_PWRDN,
		CTMC_NORMAL  = `CTMC_MODE_NORMAL,
		CTMC_RXONLY  = `CTMC_MODE_RXONLY,
		CTMC_STANDBY = `CTMC_MODE_STANDBY
	} ctmc_mode_t;

	// Buffer counter type.
	typedef logic [`CTMC_BUF_CNT_W-1:0] ctmc_cnt_t;

endpackage : ctmc_pkg

// ==== hw/ctmc_top.sv ====
// Mode controller, transmit gate and receive path of a high-speed CAN transceiver.
//
// How it works
// - A low transmit input with the transmitter on drives dominant; receive reads low.
// - Exactly normal, receive-only and standby modes exist, plus power-down.
// - Only standby select, the two supplies and reset change mode; wake-up never does.
// - In standby a detected wake-up is shown to the controller on receive data.
// - Logic-supply loss forces power-down; transmitter, receivers and bias all off.
// - Normal mode enables the transmitter and biases the bus to half supply.
// - Normal mode uses the normal receiver for receive data; low-power receiver off.
// - Normal mode enables the time-out monitor, which cuts the transmitter.
// - Normal mode enables overtemperature protection, which cuts the transmitter.
// - Transmitter-supply loss in normal mode moves to receive-only mode.
// - Standby select low with the transmitter supply good moves standby or receive-only into normal mode.
// - Normal mode is entered only with both supplies good.
// - Standby select low with transmitter supply missing means receive-only mode, except from standby, which holds.
// - Receive-only mode disables the transmitter and blocks transmit data.
// - Receive-only mode uses the normal receiver; low-power receiver off.
// - Receive-only: bias to ground, monitors off, supply detection still on.
// - Standby select high in receive-only mode enters standby.
// - Leaving power-down with select low gives normal or receive-only by supply.
// - Standby keeps only the low-power receiver watching for wake patterns.
// - An undriven standby select reads high, selecting standby.
// - Standby select high moves normal or receive-only into standby.
// - Standby never goes to receive-only; it holds while the transmitter supply is missing.
// - In standby receive data stays high until a wake-up is detected.
`timescale 1ns/1ns
`default_nettype none
`include "ctmc_params.svh"

module ctmc_top (
	// Clock and reset.
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	// Supply flags.
	input  wire logic              tx_supply_good_i,
	input  wire logic              logic_supply_good_i,
	// Controller side.
	input  wire logic              tx_data_i,
	input  wire logic              standby_select_in_i,
	input  wire logic              standby_select_driven_i,
	// Receiver and protection flags.
	input  wire logic              bus_rx_dominant_i,
	input  wire logic              lp_rx_dominant_i,
	input  wire logic              wake_pattern_i,
	input  wire logic              tx_timeout_i,
	input  wire logic              overtemp_i,
	// Receive sample stream into the buffer.
	input  wire logic              rx_sample_valid_i,
	output logic                   rx_sample_ready_o,
	// Receive data toward the controller.
	output logic                   rx_data_o,
	output logic                   rx_valid_o,
	input  wire logic              rx_ready_i,
	// Bus lines, output enables low while driving.
	output logic                   bus_high_line_o,
	output logic                   bus_high_line_oe_b_o,
	output logic                   bus_low_line_o,
	output logic                   bus_low_line_oe_b_o,
	// Mode and function enables.
	output ctmc_pkg::ctmc_mode_t   mode_o,
	output logic                   tx_enable_o,
	output logic                   nm_rx_enable_o,
	output logic                   lp_rx_enable_o,
	output logic                   bias_half_supply_o,
	output logic                   bias_ground_o,
	output logic                   tx_timeout_en_o,
	output logic                   overtemp_en_o,
	output logic                   tx_uv_detect_en_o,
	output logic                   wake_flag_o
);
	import ctmc_pkg::*;

	logic        rst_src_b;
	logic        rst_meta_r;
	logic        rst_n_r;
	logic        stb_eff;
	ctmc_mode_t  mode_r;
	ctmc_mode_t  mode_nxt;
	logic        wake_r;
	logic        tx_dom_r;
	logic        rx_bit_w;
	logic        buf_mem_r [0:`CTMC_BUF_DEPTH-1];
	logic [`CTMC_BUF_PTR_W-1:0] wr_ptr_r;
	logic [`CTMC_BUF_PTR_W-1:0] rd_ptr_r;
	ctmc_cnt_t   count_r;
	logic        push;
	logic        pop;

	// Receive level for the current mode; a recessive bus reads high.
	function automatic logic rx_level(input ctmc_mode_t m, input logic wake,
		input logic nm_dom, input logic lp_dom);
		logic lvl;
		lvl = `CTMC_RX_RECESSIVE;
		case (m)
			CTMC_NORMAL:  lvl = ~nm_dom;
			CTMC_RXONLY:  lvl = ~nm_dom;
			CTMC_STANDBY: lvl = wake ? ~lp_dom : `CTMC_RX_RECESSIVE;
			default:      lvl = `CTMC_RX_RECESSIVE;
		endcase
		return lvl;
	endfunction : rx_level

	// supply loss resets
	// Logic-supply loss acts as an asynchronous reset, so no clock edge is needed to power down.
	assign rst_src_b = rst_b_i & logic_supply_good_i;

	// Reset release through two flip-flops; assertion stays asynchronous.
	always_ff @(posedge ref_clk_i or negedge rst_src_b) begin
		if (!rst_src_b) begin
			rst_meta_r <= 1'h0;
			rst_n_r    <= 1'h0;
		end else begin
			rst_meta_r <= 1'h1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// undriven select high
	// The pull-up is modelled here: a floating select pin counts as standby.
	assign stb_eff = standby_select_driven_i ? standby_select_in_i : 1'h1;

	// four states only
	// Next mode; the wake input is deliberately absent from this decision.
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			CTMC_PWRDN: begin
				if (stb_eff) begin
					mode_nxt = CTMC_STANDBY;
				end else if (tx_supply_good_i) begin
					mode_nxt = CTMC_NORMAL;
				end else begin
					mode_nxt = CTMC_RXONLY;
				end
			end
			CTMC_NORMAL: begin
				if (stb_eff) begin
					mode_nxt = CTMC_STANDBY;
				end else if (!tx_supply_good_i) begin
					mode_nxt = CTMC_RXONLY;
				end
			end
			CTMC_RXONLY: begin
				if (stb_eff) begin
					mode_nxt = CTMC_STANDBY;
				end else if (tx_supply_good_i) begin
					mode_nxt = CTMC_NORMAL;
				end
			end
			CTMC_STANDBY: begin
				if (!stb_eff && tx_supply_good_i) begin
					mode_nxt = CTMC_NORMAL;
				end
			end
			default: mode_nxt = CTMC_PWRDN;
		endcase
	end

	// mode change causes
	// Mode register; the logic supply good is already folded into the reset.
	always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mode_r <= CTMC_PWRDN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// wake flag capture
	// Entering normal mode clears the flag even if a pattern ends in that cycle.
	always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wake_r <= 1'h0;
		end else if (mode_nxt == CTMC_NORMAL) begin
			wake_r <= 1'h0;
		end else if (mode_r == CTMC_STANDBY && wake_pattern_i) begin
			wake_r <= 1'h1;
		end
	end

	// transmitter gating
	// Time-out and overtemperature cut the enable at once and the bus driver at the next clock edge.
	assign tx_enable_o = (mode_r == CTMC_NORMAL) & ~tx_timeout_i & ~overtemp_i;

	// dominant drive
	// Registered drive so the bus lines never glitch on decode changes.
	always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tx_dom_r <= 1'h0;
		end else begin
			tx_dom_r <= tx_enable_o & ~tx_data_i;
		end
	end

	// Recessive leaves both lines undriven; only dominant drives them apart.
	assign bus_high_line_o      = tx_dom_r;
	assign bus_low_line_o       = 1'h0;
	assign bus_high_line_oe_b_o = ~tx_dom_r;
	assign bus_low_line_oe_b_o  = ~tx_dom_r;

	// receiver selection
	// Normal and receive-only use the normal receiver, standby the low-power one.
	assign nm_rx_enable_o = (mode_r == CTMC_NORMAL) | (mode_r == CTMC_RXONLY);
	assign lp_rx_enable_o = (mode_r == CTMC_STANDBY);

	// function enables by mode
	// Power-down drives neither bias, so the bus floats.
	assign bias_half_supply_o = (mode_r == CTMC_NORMAL);
	assign bias_ground_o      = (mode_r == CTMC_RXONLY) | (mode_r == CTMC_STANDBY);
	assign tx_timeout_en_o    = (mode_r == CTMC_NORMAL);
	assign overtemp_en_o      = (mode_r == CTMC_NORMAL);
	assign tx_uv_detect_en_o  = (mode_r == CTMC_NORMAL) | (mode_r == CTMC_RXONLY);
	assign mode_o             = mode_r;
	assign wake_flag_o        = wake_r;

	assign rx_bit_w = rx_level(mode_r, wake_r, bus_rx_dominant_i, lp_rx_dominant_i);

	// Buffer handshakes; power-down accepts nothing.
	assign rx_sample_ready_o = (count_r != `CTMC_BUF_FULL_CNT) & (mode_r != CTMC_PWRDN);
	assign push              = rx_sample_valid_i & rx_sample_ready_o;
	assign rx_valid_o        = (count_r != 2'h0);
	assign pop               = rx_valid_o & rx_ready_i;
	assign rx_data_o         = buf_mem_r[rd_ptr_r];

	// Buffer storage; two entries let a one-cycle stall pass without losing a bit.
	always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			buf_mem_r[0] <= `CTMC_RX_RECESSIVE;
			buf_mem_r[1] <= `CTMC_RX_RECESSIVE;
		end else if (push) begin
			buf_mem_r[wr_ptr_r] <= rx_bit_w;
		end
	end

	// Buffer pointers and fill count.
	always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_ptr_r <= 1'h0;
			rd_ptr_r <= 1'h0;
			count_r  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'h1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'h1;
			end
			if (push && !pop) begin
				count_r <= count_r + 2'h1;
			end else if (pop && !push) begin
				count_r <= count_r - 2'h1;
			end
		end
	end

	// Checks on the mode controller and data path.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_r);

	a_dom_drive_bus: assert property (tx_enable_o && !tx_data_i |=>
		!bus_high_line_oe_b_o && bus_high_line_o && !bus_low_line_o)
		else $error("dominant not driven");
	a_mode_legal: assert property (mode_r inside {CTMC_PWRDN, CTMC_NORMAL,
		CTMC_RXONLY, CTMC_STANDBY})
		else $error("illegal mode");
	a_wake_no_mode: assert property (mode_r == CTMC_STANDBY && stb_eff
		&& wake_pattern_i |=> mode_r == CTMC_STANDBY)
		else $error("wake changed mode");
	a_wake_shows_rx: assert property (mode_r == CTMC_STANDBY && wake_r
		&& lp_rx_dominant_i |-> !rx_bit_w)
		else $error("wake not on receive");
	a_pd_all_off: assert property (mode_r == CTMC_PWRDN |-> !tx_enable_o
		&& !nm_rx_enable_o && !lp_rx_enable_o && !bias_half_supply_o && !bias_ground_o)
		else $error("power-down not off");
	a_normal_funcs: assert property (mode_r == CTMC_NORMAL |-> bias_half_supply_o
		&& nm_rx_enable_o && !lp_rx_enable_o && tx_timeout_en_o && overtemp_en_o)
		else $error("normal functions wrong");
	a_fault_cut_tx: assert property (tx_timeout_i || overtemp_i |=>
		bus_high_line_oe_b_o && bus_low_line_oe_b_o)
		else $error("fault did not cut driver");
	a_uv_to_rxonly: assert property (mode_r == CTMC_NORMAL && !stb_eff
		&& !tx_supply_good_i |=> mode_r == CTMC_RXONLY)
		else $error("no receive-only on undervoltage");
	a_norm_needs_vcc: assert property ($changed(mode_r) && mode_r == CTMC_NORMAL
		|-> $past(tx_supply_good_i))
		else $error("normal without supply");
	a_rxonly_blocks: assert property (mode_r == CTMC_RXONLY |-> !tx_enable_o
		&& bias_ground_o && !tx_timeout_en_o && !overtemp_en_o && tx_uv_detect_en_o
		&& nm_rx_enable_o && !lp_rx_enable_o ##1 bus_high_line_oe_b_o)
		else $error("receive-only functions wrong");
	a_to_standby: assert property (mode_r inside {CTMC_NORMAL, CTMC_RXONLY}
		&& stb_eff |=> mode_r == CTMC_STANDBY)
		else $error("no standby entry");
	a_pd_exit: assert property (mode_r == CTMC_PWRDN && !stb_eff |=>
		mode_r == ($past(tx_supply_good_i) ? CTMC_NORMAL : CTMC_RXONLY))
		else $error("wrong power-down exit");
	a_stby_no_rxonly: assert property (mode_r == CTMC_STANDBY |=>
		mode_r != CTMC_RXONLY)
		else $error("standby went receive-only");
	a_stby_rx_high: assert property (mode_r == CTMC_STANDBY && !wake_r
		|-> rx_bit_w)
		else $error("receive low before wake");

	// Main scenarios.
	c_uv_fallback: cover property (mode_r == CTMC_NORMAL ##1 mode_r == CTMC_RXONLY);
	c_wake_seen: cover property (mode_r == CTMC_STANDBY && wake_pattern_i ##1 wake_r);
	c_buf_full: cover property (count_r == `CTMC_BUF_FULL_CNT && !rx_ready_i);
	c_stby_to_norm: cover property (mode_r == CTMC_STANDBY ##1 mode_r == CTMC_NORMAL);

endmodule : ctmc_top
`default_nettype wire

// ==== testbench/ctmc_ctrl_model.sv ====
// Behavioural CAN controller that sends transmit data and takes receive data.
`timescale 1ns/1ns
`default_nettype none

module ctmc_ctrl_model (
	// Clock and stall control.
	input  wire logic ref_clk_i,
	input  wire logic stall_i,
	// Controller pins.
	output logic      tx_data_o,
	output logic      rx_ready_o
);
	initial begin
		tx_data_o = 1'h1;
		rx_ready_o = 1'h0;
	end

	// Values are taken at the edge and land just after it, so no race with the design.
	always @(posedge ref_clk_i) begin
		tx_data_o <= #2 1'($urandom_range(1));
		rx_ready_o <= #2 !stall_i;
	end
endmodule : ctmc_ctrl_model
`default_nettype wire

// ==== testbench/test_ctmc_top.sv ====
// Self-checking bench of the CAN transceiver mode controller.
`timescale 1ns/1ns
`default_nettype none
`include "ctmc_params.svh"

module test_ctmc_top;
	import ctmc_pkg::*;
	logic       ref_clk_i = 1'h0;
	logic       rst_b_i = 1'h0;
	logic       txg = 1'h1, lg = 1'h1, sel = 1'h1, sdrv = 1'h1, lpd = 1'h0, wk = 1'h0;
	logic       tmo = 1'h0, ot = 1'h0, sv = 1'h0, odom = 1'h0, stall = 1'h0;
	logic       txd, rdy, srdy, rd, rv, bh, bhb, bl, blb, bdom, wf;
	logic [7:0] en;
	ctmc_mode_t mo, em, nm;
	logic       ewk, edrv, es, b, pu;
	logic       q[$];
	int         rs, n, phase, miscompares, compares;

	// The bus reads dominant while this node drives or another node does.
	assign bdom = !bhb | odom;

	ctmc_top i_ctmc_top (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tx_supply_good_i(txg),
		.logic_supply_good_i(lg), .tx_data_i(txd), .standby_select_in_i(sel),
		.standby_select_driven_i(sdrv), .bus_rx_dominant_i(bdom), .lp_rx_dominant_i(lpd),
		.wake_pattern_i(wk), .tx_timeout_i(tmo), .overtemp_i(ot), .rx_sample_valid_i(sv),
		.rx_sample_ready_o(srdy), .rx_data_o(rd), .rx_valid_o(rv), .rx_ready_i(rdy),
		.bus_high_line_o(bh), .bus_high_line_oe_b_o(bhb), .bus_low_line_o(bl),
		.bus_low_line_oe_b_o(blb), .mode_o(mo), .tx_enable_o(en[7]), .nm_rx_enable_o(en[6]),
		.lp_rx_enable_o(en[5]), .bias_half_supply_o(en[4]), .bias_ground_o(en[3]),
		.tx_timeout_en_o(en[2]), .overtemp_en_o(en[1]), .tx_uv_detect_en_o(en[0]),
		.wake_flag_o(wf)
	);

	ctmc_ctrl_model i_ctmc_ctrl_model (
		.ref_clk_i(ref_clk_i), .stall_i(stall), .tx_data_o(txd), .rx_ready_o(rdy)
	);

	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 ref_clk_i = !ref_clk_i;

	function automatic logic flip(int k);
		return $urandom_range(k - 1) == 0;
	endfunction : flip

	task check_mode(ctmc_mode_t e, ctmc_mode_t g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value mode expected %h seen %h", e, g);
		end
	endtask : check_mode

	task check_vec(string nm_s, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm_s, e, g);
		end
	endtask : check_vec

	task model_reset;
		rs = 0;
		em = CTMC_PWRDN;
		ewk = 1'h0;
		edrv = 1'h0;
		q.delete();
	endtask : model_reset

	// Random stimulus; the fill and drain phases keep the logic supply up.
	always @(posedge ref_clk_i) begin
		sel <= #2 flip(12) ? !sel : sel;
		sdrv <= #2 flip(20) ? !sdrv : sdrv;
		txg <= #2 flip(10) ? !txg : txg;
		lg <= #2 (phase != 0) ? 1'h1 : (lg ? !flip(400) : flip(3));
		wk <= #2 flip(6);
		lpd <= #2 flip(2);
		odom <= #2 flip(4);
		tmo <= #2 flip(8);
		ot <= #2 flip(8);
		sv <= #2 (phase == 2) ? 1'h0 : (phase == 1 || !flip(4));
		stall <= #2 (phase == 1) ? 1'h1 : flip(2);
	end

	// Reference model, stepped at each edge from the inputs seen at that edge.
	always @(posedge ref_clk_i) begin
		if (!rst_b_i || !lg) begin
			model_reset();
		end else if (rs < 2) begin
			rs++;
		end else begin
			es = sdrv ? sel : 1'h1;
			b = (em == CTMC_NORMAL || em == CTMC_RXONLY) ? !bdom :
				(em == CTMC_STANDBY && ewk) ? !lpd : 1'h1;
			// A full buffer refuses a push even when a pop frees a slot at the same edge.
			pu = sv && q.size() < `CTMC_BUF_DEPTH && em != CTMC_PWRDN;
			if (q.size() > 0 && rdy) q.pop_front();
			if (pu) begin
				q.push_back(b);
			end
			edrv = em == CTMC_NORMAL && !tmo && !ot && !txd;
			case (em)
				CTMC_PWRDN: nm = es ? CTMC_STANDBY : (txg ? CTMC_NORMAL : CTMC_RXONLY);
				CTMC_NORMAL: nm = es ? CTMC_STANDBY : (txg ? CTMC_NORMAL : CTMC_RXONLY);
				CTMC_RXONLY: nm = es ? CTMC_STANDBY : (txg ? CTMC_NORMAL : CTMC_RXONLY);
				default: nm = (!es && txg) ? CTMC_NORMAL : CTMC_STANDBY;
			endcase
			ewk = (nm == CTMC_NORMAL) ? 1'h0 : (ewk | (em == CTMC_STANDBY && wk));
			em = nm;
		end
	end

	// Outputs are settled at the falling edge; reset acts at once.
	always @(negedge ref_clk_i) begin
		if (!rst_b_i || !lg) model_reset();
		check_mode(em, mo);
		check_vec("enables", {em == CTMC_NORMAL && !tmo && !ot, em == CTMC_NORMAL ||
			em == CTMC_RXONLY, em == CTMC_STANDBY, em == CTMC_NORMAL, em == CTMC_RXONLY ||
			em == CTMC_STANDBY, em == CTMC_NORMAL, em == CTMC_NORMAL, em == CTMC_NORMAL ||
			em == CTMC_RXONLY}, en);
		check_vec("bus", {4'h0, !edrv, !edrv, edrv, 1'h0}, {4'h0, bhb, blb, bh, bl});
		check_vec("buffer", {5'h0, rs == 2 && em != CTMC_PWRDN && q.size() < `CTMC_BUF_DEPTH,
			q.size() > 0, ewk}, {5'h0, srdy, rv, wf});
		if (q.size() > 0) check_vec("rx data", 8'(q[0]), 8'(rd));
	end

	task automatic wait_lvl(ref logic s, input logic v);
		for (n = 0; n < 50 && s !== v; n++) @(negedge ref_clk_i);
		if (s !== v) begin
			miscompares++;
			finish_test();
		end
	endtask : wait_lvl

	task finish_test;
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	// Main sequence: random run, mid-run reset, buffer fill and drain, random run.
	initial begin
		phase = 0;
		miscompares = 0;
		compares = 0;
		void'($urandom(32'hec52a737));
		repeat (20) @(posedge ref_clk_i);
		rst_b_i <= #2 1'h1;
		repeat (3000) @(posedge ref_clk_i);
		rst_b_i <= #2 1'h0;
		repeat (3) @(posedge ref_clk_i);
		rst_b_i <= #2 1'h1;
		repeat (6) @(negedge ref_clk_i);
		phase = 1;
		wait_lvl(srdy, 1'h0);
		phase = 2;
		wait_lvl(rv, 1'h0);
		phase = 0;
		repeat (2000) @(posedge ref_clk_i);
		finish_test();
	end
endmodule : test_ctmc_top
`default_nettype wire
